// file: bench/mag_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module mag_trig_src (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic slow,
   input  wire logic qual,
   input  wire logic meas_done,
   output var  logic trig_a,
   output logic      trig_b,
   output logic      result_ack
);
   logic [3:0] cnt_r;
   logic [7:0] ack_r;
   assign trig_b = qual;
   assign result_ack = (ack_r == 8'h01);
   // comparator output stands still while not running
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r <= 4'h0;
         trig_a <= 1'b0;
      end else if (run) begin
         cnt_r <= cnt_r + 4'h1;
         trig_a <= trig_a ^ (&cnt_r);
      end
   end
   // result processing takes 2 or 200 cycles
   always_ff @(posedge mclk) begin
      if (rst) ack_r <= 8'h00;
      else if (meas_done) ack_r <= slow ? 8'hC8 : 8'h02;
      else if (ack_r != 8'h00) ack_r <= ack_r - 8'h01;
   end
endmodule : mag_trig_src
`default_nettype wire

// file: bench/measurement_arming_gate_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module measurement_arming_gate_control_test;
   typedef struct packed {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} mag_row_t;
   logic        mclk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, run = 1'b0, slow = 1'b0, qual = 1'b0;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wd = 32'h0, rdat, q, f, r0;
   logic        wq, ta, tb, ack, gate, done, frz, gq = 1'b0;
   int          n_mismatch = 0, comparisons = 0, cyc = 0, glen = 0;
   mag_row_t    rows [17] = '{
      '{1'b0, mag_pkg::OFS_CTRL, 32'h0, 32'h10}, '{1'b0, mag_pkg::OFS_HOLD, 32'h0, 32'h4},
      '{1'b0, mag_pkg::OFS_ARMD, 32'h0, 32'h2}, '{1'b0, mag_pkg::OFS_MEAS, 32'h0, 32'h14},
      '{1'b0, mag_pkg::OFS_SYNC, 32'h0, 32'h2}, '{1'b0, mag_pkg::OFS_IGN, 32'h0, 32'h8},
      '{1'b0, mag_pkg::OFS_WIN, 32'h0, 32'h2}, '{1'b0, mag_pkg::OFS_CMD, 32'h0, 32'h0},
      '{1'b0, 6'h28, 32'h0, 32'h0}, '{1'b1, mag_pkg::OFS_HOLD, 32'h0, 32'h2},
      '{1'b1, mag_pkg::OFS_SYNC, 32'h2FAF081, 32'h2FAF080}, '{1'b1, mag_pkg::OFS_IGN, 32'h1, 32'h8},
      '{1'b1, mag_pkg::OFS_ARMD, 32'hF42401, 32'hF42400}, '{1'b1, mag_pkg::OFS_HOLD, 32'h4, 32'h4},
      '{1'b1, mag_pkg::OFS_CMD, 32'h4, 32'h0}, '{1'b0, mag_pkg::OFS_IGN, 32'h0, 32'h2625A0},
      '{1'b0, mag_pkg::OFS_WIN, 32'h0, 32'h1312D00}};
   mag_ctrl #(.HOLD_RST(28'h4), .MEAS_RST(28'h14)) u_dut (
      .mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wq), .trig_a(ta), .trig_b(tb),
      .result_ack(ack), .gate_open(gate), .meas_done(done), .frozen(frz));
   mag_trig_src u_src (
      .mclk(mclk), .rst(rst), .run(run), .slow(slow), .qual(qual), .meas_done(done),
      .trig_a(ta), .trig_b(tb), .result_ack(ack));
   initial begin
      forever #2 mclk = ~mclk;
   end
   task automatic print_verdict();
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      adr <= a;
      wd <= d;
      rd <= ~w;
      wr <= w;
      do @(posedge mclk); while (wq !== 1'b0);
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic wt(input logic s, input int lim, output logic [31:0] r);
      r = 32'h0;
      repeat (lim) begin
         @(negedge mclk);
         if ((s ? gate : done) === 1'b1) begin
            r = 32'h1;
            break;
         end
      end
      @(posedge mclk);
   endtask : wt
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      gq <= gate;
      if (gate & ~gq) glen <= 0;
      else if (gate) glen <= glen + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("reset_out", 32'h0, {29'h0, gate, done, frz});
      for (int i = 0; i < 17; i++) begin
         bus(rows[i].w, rows[i].a, rows[i].d, q);
         if (rows[i].w) bus(1'b0, rows[i].a, 32'h0, q);
         chk("reg", rows[i].e, q);
      end
      run <= 1'b1;
      wt(1'b1, 2000, f); chk("first_gate", 32'h1, f);
      wt(1'b0, 2000, f); chk("first_done", 32'h1, f);
      chk("gate_len", 32'h1, 32'(glen >= 474));
      wt(1'b1, 300, f); chk("auto_rearm", 32'h1, f);
      slow <= 1'b1;
      wt(1'b0, 2000, f);
      wt(1'b1, 150, f); chk("wait_ack", 32'h0, f);
      wt(1'b1, 300, f); chk("after_ack", 32'h1, f);
      bus(1'b1, mag_pkg::OFS_CMD, 32'h1, q); chk("frozen", 32'h1, 32'(frz));
      wt(1'b0, 2000, f);
      bus(1'b0, mag_pkg::OFS_RES, 32'h0, r0);
      bus(1'b1, mag_pkg::OFS_MEAS, 32'h28, q);
      wt(1'b0, 3000, f);
      wt(1'b0, 3000, f);
      bus(1'b0, mag_pkg::OFS_RES, 32'h0, q); chk("res_held", r0, q);
      bus(1'b1, mag_pkg::OFS_CMD, 32'h1, q); chk("thawed", 32'h0, 32'(frz));
      wt(1'b0, 3000, f); chk("long_gate", 32'h1, 32'(glen >= 974));
      bus(1'b1, mag_pkg::OFS_CTRL, 32'h11, q);
      wt(1'b1, 600, f); chk("man_idle", 32'h0, f);
      bus(1'b1, mag_pkg::OFS_CMD, 32'h2, q);
      wt(1'b1, 300, f); chk("man_shot", 32'h1, f);
      wt(1'b0, 3000, f);
      wt(1'b1, 600, f); chk("man_once", 32'h0, f);
      bus(1'b1, mag_pkg::OFS_CTRL, 32'h12, q);
      wt(1'b1, 600, f); chk("ext_idle", 32'h0, f);
      qual <= 1'b1;
      wt(1'b1, 300, f); chk("ext_b", 32'h1, f);
      qual <= 1'b0;
      wt(1'b0, 3000, f);
      bus(1'b1, mag_pkg::OFS_ARMD, 32'h14, q);
      bus(1'b1, mag_pkg::OFS_CTRL, 32'h1A, q);
      wt(1'b1, 400, f);
      qual <= 1'b1;
      wt(1'b1, 440, f); chk("arm_delay", 32'h0, f);
      wt(1'b1, 400, f); chk("arm_start", 32'h1, f);
      qual <= 1'b0;
      wt(1'b0, 3000, f);
      bus(1'b1, mag_pkg::OFS_CTRL, 32'hD2, q);
      wt(1'b1, 600, f); chk("ext_pavg_free", 32'h1, f);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("rerun_out", 32'h0, {29'h0, gate, done, frz});
      bus(1'b0, mag_pkg::OFS_HOLD, 32'h0, q); chk("rerun_hold", 32'h4, q);
      print_verdict();
   end
endmodule : measurement_arming_gate_control_test
`default_nettype wire

// file: logic/mag_ctrl.sv
// What this block does
// - free-run mode re-arms automatically after each finished measurement.
// - start needs prior result processed, preparation done, then an input trigger.
// - outside burst mode, frequency, ratio, rpm and period-average gates last at least the measuring time less up to 100 ns.
// - gate closes on first stop-trigger event once required time expired.
// - freeze command holds the last result, blocking updates.
// - rearm in manual mode performs exactly one measurement.
// - external qualification disables free-run; every start needs a qualifier edge.
// - qualifier source selectable as channel A or channel B.
// - external qualification applies to frequency, period, pulse width, rpm, duty.
// - optional start delay after qualifier edge, 200 ns to 1.6 s, 100 ns steps.
// - while hold-off runs, start and stop triggers are ignored.
// - each measurement start launches the hold-off timer.
// - after hold-off elapses, start and stop triggers are accepted again.
// - hold-off 200 ns to 1.6 s, 100 ns resolution, default 10 us.
// - actual hold-off lies between programmed value and 100 ns less.
// - burst sync delay settable 200 ns to 5 s.
// - autoset lengthens sync delay stepwise until bursts synchronise.
// - ignore-start interval 800 ns to 5 s before the burst gate.
// - autoset sets ignore-start to 5 percent of sync delay.
// - burst measuring window opens on the first accepted start trigger after ignore-start ends.
// - autoset sets burst window to 40 percent of sync delay.
// - measuring time defaults 100 ms, adjustable continuously up to 15 s.
// - gate start and stop always synchronised to input trigger events.
`timescale 1ns/1ps
`default_nettype none
module mag_ctrl #(
   parameter logic [mag_pkg::TW-1:0] HOLD_RST = mag_pkg::HOLD_RST_TK,
   parameter logic [mag_pkg::TW-1:0] MEAS_RST = mag_pkg::MEAS_RST_TK
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        trig_a,
   input  wire logic        trig_b,
   input  wire logic        result_ack,
   output var  logic        gate_open,
   output var  logic        meas_done,
   output var  logic        frozen
);
   localparam int TW = mag_pkg::TW;

   typedef enum logic [8:0] {
      S_DONE   = 9'h001, S_PREP  = 9'h002, S_WQUAL = 9'h004,
      S_ARMD   = 9'h008, S_WSTART = 9'h010, S_IGN  = 9'h020,
      S_WOPEN  = 9'h040, S_GATE  = 9'h080, S_WSYNC = 9'h100
   } mag_state_t;

   function automatic logic [TW-1:0] clamp(input logic [31:0] v, input logic [TW-1:0] lo,
                                           input logic [TW-1:0] hi);
      if (v < 32'(lo))
         clamp = lo;
      else if (v > 32'(hi))
         clamp = hi;
      else
         clamp = v[TW-1:0];
   endfunction : clamp

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i])
            merge[8*i +: 8] = wd[8*i +: 8];
      end
   endfunction : merge

   function automatic logic is_timed(input mag_pkg::mag_func_t f);
      is_timed = (f == mag_pkg::FN_FREQ) || (f == mag_pkg::FN_RATIO) ||
                 (f == mag_pkg::FN_RPM) || (f == mag_pkg::FN_PAVG);
   endfunction : is_timed

   function automatic logic ext_ok(input mag_pkg::mag_func_t f);
      ext_ok = (f == mag_pkg::FN_FREQ) || (f == mag_pkg::FN_PER) || (f == mag_pkg::FN_PW) ||
               (f == mag_pkg::FN_RPM) || (f == mag_pkg::FN_DUTY);
   endfunction : ext_ok

   // pin conditioning
   logic [2:0] sa_r;
   logic [2:0] sb_r;
   logic       lva_r;
   logic       lvb_r;
   logic       pva_r;
   logic       pvb_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sa_r  <= 3'h0;
         sb_r  <= 3'h0;
         lva_r <= 1'b0;
         lvb_r <= 1'b0;
         pva_r <= 1'b0;
         pvb_r <= 1'b0;
      end else begin
         sa_r  <= {sa_r[1:0], trig_a};
         sb_r  <= {sb_r[1:0], trig_b};
         if (sa_r[2] == sa_r[1])
            lva_r <= sa_r[2];
         if (sb_r[2] == sb_r[1])
            lvb_r <= sb_r[2];
         pva_r <= lva_r;
         pvb_r <= lvb_r;
      end
   end

   logic rise_a;
   logic fall_a;
   logic rise_b;
   assign rise_a = lva_r & ~pva_r;
   assign fall_a = ~lva_r & pva_r;
   assign rise_b = lvb_r & ~pvb_r;

   // 100 ns reference tick
   logic [4:0] pre_r;
   logic       tick;
   assign tick = (pre_r == 5'(mag_pkg::TICK_CYC - 1));
   always_ff @(posedge mclk) begin
      if (rst || tick)
         pre_r <= 5'h00;
      else
         pre_r <= pre_r + 5'h01;
   end

   // register file and bus slave
   logic [7:0]    ctrl_r;
   logic [TW-1:0] hold_r;
   logic [TW-1:0] armd_r;
   logic [TW-1:0] meas_r;
   logic [TW-1:0] sync_r;
   logic [TW-1:0] ign_r;
   logic [TW-1:0] win_r;
   logic [31:0]   res_r;
   logic          ack_r;
   logic          auto_r;
   logic          single_r;
   logic          pend_r;
   logic          auto_bump;
   logic          auto_end;
   logic          wr;
   logic          cmd_wr;
   logic [TW-1:0] sync_nxt;
   mag_state_t    st_r;
   mag_state_t    st_nxt;

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr       = avs_write & ack_r;
   assign cmd_wr   = wr && (avs_address == mag_pkg::OFS_CMD) && avs_byteenable[0];
   assign sync_nxt = clamp(32'(sync_r) + 32'(mag_pkg::AUTO_STEP_TK), mag_pkg::MIN200_TK, mag_pkg::MAX5S_TK);

   mag_pkg::mag_mode_t mode;
   mag_pkg::mag_func_t func;
   logic               ext_act;
   logic               burst;
   assign mode    = mag_pkg::mag_mode_t'(ctrl_r[mag_pkg::CTL_MODE +: 2]);
   assign func    = mag_pkg::mag_func_t'(ctrl_r[mag_pkg::CTL_FUNC +: 3]);
   assign ext_act = (mode == mag_pkg::MODE_EXT) && ext_ok(func);
   assign burst   = (mode == mag_pkg::MODE_BURST);

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r <= mag_pkg::CTRL_RST;
         hold_r <= HOLD_RST;
         armd_r <= mag_pkg::MIN200_TK;
         meas_r <= MEAS_RST;
         sync_r <= mag_pkg::MIN200_TK;
         ign_r  <= mag_pkg::MIN800_TK;
         win_r  <= mag_pkg::MIN200_TK;
      end else begin
         if (wr) begin
            case (avs_address)
               mag_pkg::OFS_CTRL: ctrl_r <= 8'(merge({24'h0, ctrl_r}, avs_writedata, avs_byteenable));
               mag_pkg::OFS_HOLD: hold_r <= clamp(merge(32'(hold_r), avs_writedata, avs_byteenable),
                                                  mag_pkg::MIN200_TK, mag_pkg::MAX1600MS_TK);
               mag_pkg::OFS_ARMD: armd_r <= clamp(merge(32'(armd_r), avs_writedata, avs_byteenable),
                                                  mag_pkg::MIN200_TK, mag_pkg::MAX1600MS_TK);
               mag_pkg::OFS_MEAS: meas_r <= clamp(merge(32'(meas_r), avs_writedata, avs_byteenable),
                                                  mag_pkg::MIN200_TK, mag_pkg::MAX15S_TK);
               mag_pkg::OFS_SYNC: sync_r <= clamp(merge(32'(sync_r), avs_writedata, avs_byteenable),
                                                  mag_pkg::MIN200_TK, mag_pkg::MAX5S_TK);
               mag_pkg::OFS_IGN:  ign_r  <= clamp(merge(32'(ign_r), avs_writedata, avs_byteenable),
                                                  mag_pkg::MIN800_TK, mag_pkg::MAX5S_TK);
               mag_pkg::OFS_WIN:  win_r  <= clamp(merge(32'(win_r), avs_writedata, avs_byteenable),
                                                  mag_pkg::MIN200_TK, mag_pkg::MAX5S_TK);
               default: ;
            endcase
         end
         // autoset derives ignore-start and window from the sync delay
         if (auto_bump) begin
            sync_r <= sync_nxt;
            ign_r  <= clamp(32'(sync_nxt) / 32'd20, mag_pkg::MIN800_TK, mag_pkg::MAX5S_TK);
            win_r  <= clamp(32'(sync_nxt) * 32'd2 / 32'd5, mag_pkg::MIN200_TK, mag_pkg::MAX5S_TK);
         end else if (cmd_wr && avs_writedata[mag_pkg::CMD_AUTO]) begin
            ign_r  <= clamp(32'(sync_r) / 32'd20, mag_pkg::MIN800_TK, mag_pkg::MAX5S_TK);
            win_r  <= clamp(32'(sync_r) * 32'd2 / 32'd5, mag_pkg::MIN200_TK, mag_pkg::MAX5S_TK);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         case (avs_address)
            mag_pkg::OFS_CTRL: avs_readdata <= {24'h0, ctrl_r};
            mag_pkg::OFS_HOLD: avs_readdata <= 32'(hold_r);
            mag_pkg::OFS_ARMD: avs_readdata <= 32'(armd_r);
            mag_pkg::OFS_MEAS: avs_readdata <= 32'(meas_r);
            mag_pkg::OFS_SYNC: avs_readdata <= 32'(sync_r);
            mag_pkg::OFS_IGN:  avs_readdata <= 32'(ign_r);
            mag_pkg::OFS_WIN:  avs_readdata <= 32'(win_r);
            mag_pkg::OFS_STAT: avs_readdata <= {19'h0, st_r, auto_r, single_r, pend_r, frozen};
            mag_pkg::OFS_RES:  avs_readdata <= res_r;
            default:           avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // command flags; a command set beats a same-cycle hardware clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         frozen   <= 1'b0;
         single_r <= 1'b0;
         auto_r   <= 1'b0;
      end else begin
         if (cmd_wr && avs_writedata[mag_pkg::CMD_FREEZE])
            frozen <= ~frozen;
         if (cmd_wr && avs_writedata[mag_pkg::CMD_REARM])
            single_r <= 1'b1;
         else if (st_r == S_PREP && mode == mag_pkg::MODE_MAN)
            single_r <= 1'b0;
         if (cmd_wr && avs_writedata[mag_pkg::CMD_AUTO])
            auto_r <= 1'b1;
         else if (auto_end || !burst)
            auto_r <= 1'b0;
      end
   end

   // timers
   mag_tmr_if tif [mag_pkg::NTMR] ();
   logic [TW-1:0]           tval [mag_pkg::NTMR];
   logic [mag_pkg::NTMR-1:0] tld;
   logic [mag_pkg::NTMR-1:0] tbusy;
   logic [mag_pkg::NTMR-1:0] tdone;

   assign tval[mag_pkg::T_HOLD] = hold_r;
   assign tval[mag_pkg::T_ARM]  = armd_r;
   assign tval[mag_pkg::T_MEAS] = meas_r;
   assign tval[mag_pkg::T_SYNC] = sync_r;
   assign tval[mag_pkg::T_IGN]  = ign_r;
   assign tval[mag_pkg::T_WIN]  = win_r;

   for (genvar gi = 0; gi < mag_pkg::NTMR; gi++) begin : g_tmr
      assign tif[gi].load  = tld[gi];
      assign tif[gi].ticks = tval[gi];
      assign tbusy[gi]     = tif[gi].busy;
      assign tdone[gi]     = tif[gi].done;
      mag_tick_timer u_tmr (
         .mclk (mclk),
         .rst  (rst),
         .tick (tick),
         .t    (tif[gi])
      );
   end

   // sequencer
   logic hold_busy;
   logic qual_edge;
   logic start_acc;
   logic stop_evt;
   logic stop_ok;
   logic open_g;
   logic close_g;
   logic [TW-1:0] gap_r;

   assign hold_busy = tbusy[mag_pkg::T_HOLD];
   assign qual_edge = ctrl_r[mag_pkg::CTL_SRC_A] ? rise_a : rise_b;
   assign start_acc = rise_a & ~hold_busy;
   assign stop_evt  = ((func == mag_pkg::FN_PW) ? fall_a : rise_a) & ~hold_busy;
   assign stop_ok   = burst ? ~tbusy[mag_pkg::T_WIN] :
                      (~is_timed(func) | ~tbusy[mag_pkg::T_MEAS]);

   always_comb begin
      st_nxt    = st_r;
      tld       = '0;
      open_g    = 1'b0;
      close_g   = 1'b0;
      auto_bump = 1'b0;
      auto_end  = 1'b0;
      case (st_r)
         S_DONE: begin
            if (!pend_r && (mode != mag_pkg::MODE_MAN || single_r))
               st_nxt = S_PREP;
         end
         S_PREP: begin
            st_nxt = ext_act ? S_WQUAL : S_WSTART;
         end
         S_WQUAL: begin
            if (!ext_act) begin
               st_nxt = S_WSTART;
            end else if (qual_edge) begin
               if (ctrl_r[mag_pkg::CTL_DLYEN]) begin
                  st_nxt = S_ARMD;
                  tld[mag_pkg::T_ARM] = 1'b1;
               end else begin
                  st_nxt = S_WSTART;
               end
            end
         end
         S_ARMD: begin
            if (tdone[mag_pkg::T_ARM])
               st_nxt = S_WSTART;
         end
         S_WSTART: begin
            if (start_acc) begin
               if (burst) begin
                  st_nxt = S_IGN;
                  tld[mag_pkg::T_IGN]  = 1'b1;
                  tld[mag_pkg::T_SYNC] = 1'b1;
                  auto_bump = auto_r && (gap_r < mag_pkg::AUTO_GAP_TK);
                  auto_end  = auto_r && (gap_r >= mag_pkg::AUTO_GAP_TK);
               end else begin
                  st_nxt = S_GATE;
                  open_g = 1'b1;
                  tld[mag_pkg::T_MEAS] = 1'b1;
                  tld[mag_pkg::T_HOLD] = ctrl_r[mag_pkg::CTL_HOLDEN];
               end
            end
         end
         S_IGN: begin
            if (tdone[mag_pkg::T_IGN])
               st_nxt = S_WOPEN;
         end
         S_WOPEN: begin
            if (start_acc) begin
               st_nxt = S_GATE;
               open_g = 1'b1;
               tld[mag_pkg::T_WIN]  = 1'b1;
               tld[mag_pkg::T_HOLD] = ctrl_r[mag_pkg::CTL_HOLDEN];
            end
         end
         S_GATE: begin
            if (stop_ok && stop_evt) begin
               close_g = 1'b1;
               st_nxt  = burst ? S_WSYNC : S_DONE;
            end
         end
         S_WSYNC: begin
            if (!tbusy[mag_pkg::T_SYNC])
               st_nxt = S_DONE;
         end
         default: st_nxt = S_DONE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst)
         st_r <= S_DONE;
      else
         st_r <= st_nxt;
   end

   // ticks from sync-delay expiry to the next burst start edge
   always_ff @(posedge mclk) begin
      if (rst || tdone[mag_pkg::T_SYNC])
         gap_r <= '0;
      else if (tick && gap_r != {TW{1'b1}})
         gap_r <= gap_r + TW'(1);
   end

   // gate, result and hand-off
   logic [31:0] cnt_r;
   always_ff @(posedge mclk) begin
      if (rst) begin
         gate_open <= 1'b0;
         meas_done <= 1'b0;
         cnt_r     <= 32'h0000_0000;
         res_r     <= 32'h0000_0000;
         pend_r    <= 1'b0;
      end else begin
         meas_done <= close_g;
         if (open_g)
            gate_open <= 1'b1;
         else if (close_g)
            gate_open <= 1'b0;
         cnt_r <= open_g ? 32'h0000_0001 : cnt_r + 32'(gate_open);
         if (close_g && !frozen)
            res_r <= cnt_r;
         if (close_g)
            pend_r <= 1'b1;
         else if (result_ack)
            pend_r <= 1'b0;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_rearm;
      st_r == S_PREP ##1 st_r == S_WSTART;
   endsequence

   chk_free_rearm: assert property ((st_r == S_DONE && !pend_r && mode == mag_pkg::MODE_FREE) |=> s_rearm)
      else $error("free-run did not re-arm");
   chk_start_order: assert property ($rose(gate_open) |-> $past(rise_a) && !$past(hold_busy))
      else $error("gate opened without accepted trigger");
   chk_meas_time: assert property (($fell(gate_open) && !burst && is_timed(func)) |-> !$past(tbusy[mag_pkg::T_MEAS]))
      else $error("gate closed before measuring time");
   chk_stop_close: assert property ((st_r == S_GATE && stop_ok && stop_evt) |=> !gate_open && meas_done)
      else $error("stop event did not close gate");
   chk_freeze_hold: assert property ((frozen && $past(frozen)) |-> $stable(res_r))
      else $error("frozen result changed");
   chk_single_shot: assert property ((st_r == S_DONE && mode == mag_pkg::MODE_MAN && !single_r) |=> st_r == S_DONE)
      else $error("manual mode measured without rearm");
   chk_qual_wait: assert property ((st_r == S_WQUAL && ext_act && !qual_edge) |=> st_r == S_WQUAL)
      else $error("start left qualifier wait without edge");
   chk_hold_block: assert property (hold_busy |-> !open_g && !close_g)
      else $error("trigger accepted during hold-off");
   chk_hold_launch: assert property (($rose(gate_open) && ctrl_r[mag_pkg::CTL_HOLDEN]) |-> hold_busy)
      else $error("hold-off not launched at start");
endmodule : mag_ctrl
`default_nettype wire

// file: logic/mag_pkg.sv
`default_nettype none
package mag_pkg;
   localparam int CLK_MHZ  = 250;
   localparam int TICK_NS  = 100;
   localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
   localparam int TICKS_PER_MS = 1000000 / TICK_NS;
   localparam int TW = 28;

   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_CMD  = 6'h04;
   localparam logic [5:0] OFS_HOLD = 6'h08;
   localparam logic [5:0] OFS_ARMD = 6'h0C;
   localparam logic [5:0] OFS_MEAS = 6'h10;
   localparam logic [5:0] OFS_SYNC = 6'h14;
   localparam logic [5:0] OFS_IGN  = 6'h18;
   localparam logic [5:0] OFS_WIN  = 6'h1C;
   localparam logic [5:0] OFS_STAT = 6'h20;
   localparam logic [5:0] OFS_RES  = 6'h24;

   localparam int CTL_MODE  = 0;
   localparam int CTL_SRC_A = 2;
   localparam int CTL_DLYEN = 3;
   localparam int CTL_HOLDEN = 4;
   localparam int CTL_FUNC  = 5;
   localparam logic [7:0] CTRL_RST = 8'h10;
   localparam int CMD_FREEZE = 0;
   localparam int CMD_REARM  = 1;
   localparam int CMD_AUTO   = 2;

   localparam int HOLD_DEF_NS = 10000;
   localparam int MEAS_DEF_MS = 100;
   localparam logic [TW-1:0] HOLD_RST_TK = TW'(HOLD_DEF_NS / TICK_NS);
   localparam logic [TW-1:0] MEAS_RST_TK = TW'(MEAS_DEF_MS * TICKS_PER_MS);
   localparam logic [TW-1:0] MIN200_TK = TW'(200 / TICK_NS);
   localparam logic [TW-1:0] MIN800_TK = TW'(800 / TICK_NS);
   localparam logic [TW-1:0] MAX1600MS_TK = TW'(1600 * TICKS_PER_MS);
   localparam logic [TW-1:0] MAX5S_TK = TW'(5000 * TICKS_PER_MS);
   localparam logic [TW-1:0] MAX15S_TK = TW'(15000 * TICKS_PER_MS);
   localparam logic [TW-1:0] AUTO_STEP_TK = TW'(1000);
   localparam logic [TW-1:0] AUTO_GAP_TK = TW'(8);

   localparam int T_HOLD = 0;
   localparam int T_ARM  = 1;
   localparam int T_MEAS = 2;
   localparam int T_SYNC = 3;
   localparam int T_IGN  = 4;
   localparam int T_WIN  = 5;
   localparam int NTMR   = 6;

   typedef enum logic [1:0] {
      MODE_FREE = 2'h0, MODE_MAN = 2'h1, MODE_EXT = 2'h2, MODE_BURST = 2'h3
   } mag_mode_t;
   typedef enum logic [2:0] {
      FN_FREQ = 3'h0, FN_PER = 3'h1, FN_PW = 3'h2, FN_RPM = 3'h3,
      FN_DUTY = 3'h4, FN_RATIO = 3'h5, FN_PAVG = 3'h6, FN_OTHER = 3'h7
   } mag_func_t;
endpackage : mag_pkg
`default_nettype wire

// file: logic/mag_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mag_tick_timer (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick,
   mag_tmr_if.tmr   t
);
   logic [mag_pkg::TW-1:0] cnt_r;

   // counts free-running 100 ns ticks, so the first tick lands anywhere in the first slot
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r  <= '0;
         t.busy <= 1'b0;
         t.done <= 1'b0;
      end else begin
         t.done <= 1'b0;
         if (t.load) begin
            cnt_r  <= t.ticks;
            t.busy <= 1'b1;
         end else if (t.busy && tick) begin
            if (cnt_r == mag_pkg::TW'(1)) begin
               t.busy <= 1'b0;
               t.done <= 1'b1;
            end
            cnt_r <= cnt_r - mag_pkg::TW'(1);
         end
      end
   end
endmodule : mag_tick_timer
`default_nettype wire

// file: logic/mag_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mag_tmr_if;
   logic                     load;
   logic [mag_pkg::TW-1:0]   ticks;
   logic                     busy;
   logic                     done;
   modport ctl (output load, output ticks, input busy, input done);
   modport tmr (input load, input ticks, output busy, output done);
endinterface : mag_tmr_if
`default_nettype wire
